// [rtl/host_spi_device.sv]
// Device end of the host serial register port: shifts 40-bit frames on the link
// clock and hands complete commands to the register file on the system clock.
// Assumes the register file answers reg_rdata combinationally from reg_addr.
`default_nettype none

// Operation
// - Frames are fixed at forty bits.
// - One bit out for every bit in.
// - Master holds chip select low whole frame.
// - Address byte then four data bytes.
// - Bit 39 set means write, else read.
// - Reply returned on every frame.
// - After read, reply carries addressed register.
// - After write, reply echoes written data.
// - Read frames never store their data.
// - Read value captured when request arrives.
// - Status byte leads every reply.
// - Values right-aligned, signed as two's complement.
// - Chip select fall starts new transaction.
// - Sample on rising, update after falling.
// - Most significant bit travels first.
// - Master gives at least forty clocks.
// - Short frames discarded, status still first.
// - Extra bits emerge forty clocks later.
// - Chip select rise latches last forty bits.
// - Serial clock at most quarter system clock.
module host_spi_device
    import spi_port_pkg::*;
(
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    host_spi_if.device                           link,
    input  wire logic [spi_port_pkg::STATUS_BITS-1:0] event_status,
    input  wire logic [spi_port_pkg::DATA_BITS-1:0]   reg_rdata,
    output logic                                 reg_write,
    output logic                                 reg_read,
    output logic      [spi_port_pkg::ADDR_BITS-1:0]   reg_addr,
    output logic      [spi_port_pkg::DATA_BITS-1:0]   reg_wdata,
    output logic                                 frame_discarded
);
    import spi_port_pkg::*;

    // ==========================================
    // Link clock domain
    logic                  frame_rst_n;
    logic                  started;
    logic                  next_started;
    logic [CNT_W-1:0]      bit_cnt;
    logic [CNT_W-1:0]      next_bit_cnt;
    logic [FRAME_BITS-1:0] shift;
    logic [FRAME_BITS-1:0] next_shift;
    logic                  out_bit;
    logic                  shown;
    logic                  frame_tog;
    logic                  next_frame_tog;
    logic [FRAME_BITS-1:0] reply;

    // A high chip select clears the started and shown flags without any link clock edge.
    assign frame_rst_n = rst_n & ~link.host_chip_select_n;

    // The reply is loaded on the first rising edge and received bits enter at the bottom.
    always_comb
    begin
        next_started   = 1'b1;
        next_frame_tog = frame_tog;
        if (!started)
        begin
            // Flips once per frame, so the system side can tell a frame that saw no clock at all.
            next_frame_tog = ~frame_tog;
            next_bit_cnt   = 6'h01;
            next_shift   = {reply[FRAME_BITS-2:0], link.host_serial_in};
        end
        else
        begin
            next_bit_cnt = (bit_cnt == FRAME_COUNT) ? bit_cnt : bit_cnt + 6'h01;
            next_shift   = {shift[FRAME_BITS-2:0], link.host_serial_in};
        end
    end

    // The started flag is cleared by chip select; count and shift register survive the frame end
    // so the system side can read them once chip select is high again.
    always_ff @(posedge link.host_serial_clock or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            started <= 1'b0;
        else
            started <= next_started;
    end

    always_ff @(posedge link.host_serial_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bit_cnt   <= '0;
            shift     <= '0;
            frame_tog <= 1'b0;
        end
        else
        begin
            bit_cnt   <= next_bit_cnt;
            shift     <= next_shift;
            frame_tog <= next_frame_tog;
        end
    end

    // Output changes only after a falling edge, giving the master half a period of setup.
    always_ff @(negedge link.host_serial_clock or negedge rst_n)
    begin
        if (!rst_n)
            out_bit <= 1'b0;
        else
            out_bit <= shift[FRAME_BITS-1];
    end

    // Marks that this frame has had a falling edge; cleared by chip select like the started flag.
    always_ff @(negedge link.host_serial_clock or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            shown <= 1'b0;
        else
            shown <= 1'b1;
    end

    // Until the first falling edge the leading status bit comes straight from the reply, so the pin
    // never moves on a rising edge, where the master may still be sampling it.
    assign link.host_serial_out = link.host_chip_select_n ? 1'b0 :
                                  (shown ? out_bit : reply[FRAME_BITS-1]);

    // ==========================================
    // Chip select and frame toggle synchronisers
    logic [CS_SYNC_STAGES-1:0] cs_sync;
    logic [CS_SYNC_STAGES-1:0] tog_sync;
    logic                      cs_prev;
    logic                      frame_end;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_sync  <= '1;
            tog_sync <= '0;
            cs_prev  <= 1'b1;
        end
        else
        begin
            cs_sync  <= {cs_sync[CS_SYNC_STAGES-2:0], link.host_chip_select_n};
            tog_sync <= {tog_sync[CS_SYNC_STAGES-2:0], frame_tog};
            cs_prev  <= cs_sync[CS_SYNC_STAGES-1];
        end
    end

    // The master keeps chip select low for the whole frame, so its rise marks the frame end.
    assign frame_end = cs_sync[CS_SYNC_STAGES-1] & ~cs_prev;

    // ==========================================
    // Command decode on the system clock
    logic                  next_reg_write;
    logic                  next_reg_read;
    logic                  next_discard;
    logic [ADDR_BITS-1:0]  next_reg_addr;
    logic [DATA_BITS-1:0]  next_reg_wdata;
    logic [FRAME_BITS-1:0] next_reply;
    logic                  pend_read;
    logic                  next_pend_read;
    logic                  tog_seen;
    logic                  next_tog_seen;

    // Shift register and count are quiet here: no link clock edge occurs while chip select is high.
    always_comb
    begin
        next_reg_write = 1'b0;
        next_reg_read  = 1'b0;
        next_discard   = 1'b0;
        next_reg_addr  = reg_addr;
        next_reg_wdata = reg_wdata;
        next_reply     = reply;
        next_pend_read = 1'b0;
        next_tog_seen  = tog_seen;
        if (pend_read)
        begin
            // Register value taken the cycle the read is issued, not at the next frame.
            next_reply[DATA_BITS-1:0] = reg_rdata;
        end
        if (frame_end)
        begin
            next_reply[FRAME_BITS-1:DATA_BITS] = event_status;
            next_tog_seen                      = tog_sync[CS_SYNC_STAGES-1];
            // The count survives the frame end, so an unchanged toggle is what exposes a frame
            // without clocks, which would otherwise replay the previous command.
            if (bit_cnt != FRAME_COUNT || tog_sync[CS_SYNC_STAGES-1] == tog_seen)
            begin
                next_discard = 1'b1;
            end
            else
            begin
                next_reg_addr = shift[ADDR_MSB:ADDR_LSB];
                if (shift[WRITE_POS])
                begin
                    next_reg_write            = 1'b1;
                    next_reg_wdata            = shift[DATA_BITS-1:0];
                    next_reply[DATA_BITS-1:0] = shift[DATA_BITS-1:0];
                end
                else
                begin
                    // Read data bits are dummies and never reach the register file.
                    next_reg_read  = 1'b1;
                    next_pend_read = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_write       <= 1'b0;
            reg_read        <= 1'b0;
            frame_discarded <= 1'b0;
            reg_addr        <= '0;
            reg_wdata       <= '0;
            reply           <= '0;
            pend_read       <= 1'b0;
            tog_seen        <= 1'b0;
        end
        else
        begin
            reg_write       <= next_reg_write;
            reg_read        <= next_reg_read;
            frame_discarded <= next_discard;
            reg_addr        <= next_reg_addr;
            reg_wdata       <= next_reg_wdata;
            reply           <= next_reply;
            pend_read       <= next_pend_read;
            tog_seen        <= next_tog_seen;
        end
    end

    // Reply is only consistent if the link clock stays at or below a quarter of clk.
    if (CS_SYNC_STAGES < 2 || SCLK_DIV_RATIO < 4)
    begin : g_bad_ratio
        $error("host_spi_device: synchroniser or clock ratio too small.");
    end
endmodule
`default_nettype wire

// [rtl/spi_port_pkg.sv]
// Shared constants for the host serial register port: frame layout and timing.
// Assumes both ends and the bench import this package.
`default_nettype none
package spi_port_pkg;
    // ==========================================
    // Frame layout
    localparam int FRAME_BITS  = 40;
    localparam int STATUS_BITS = 8;
    localparam int ADDR_BITS   = 7;
    localparam int DATA_BITS   = 32;
    localparam int WRITE_POS   = 39;
    localparam int ADDR_MSB    = 38;
    localparam int ADDR_LSB    = 32;
    localparam int CNT_W       = 6;
    localparam logic [CNT_W-1:0] FRAME_COUNT = 6'h28;
    localparam logic [7:0]       WRITE_FLAG  = 8'h80;
    // ==========================================
    // Timing
    localparam int CLK_PERIOD_NS  = 20;
    localparam int SCLK_DIV_RATIO = 4;
    // Half period of the generated serial clock in system clocks; covers the input synchroniser.
    localparam int HALF_CYCLES    = 4;
    localparam int GAP_CYCLES     = 8;
    localparam int CS_SYNC_STAGES = 2;
    // Least chip-select high time: synchroniser, edge detect and reply update.
    localparam int CS_HIGH_MIN_CYCLES = CS_SYNC_STAGES + 3;
endpackage
`default_nettype wire

// [rtl/host_spi_if.sv]
// Four-wire link between the host master and the register port device.
// Assumes the host drives chip select, clock and data in; the device drives data out.
`default_nettype none
interface host_spi_if;
    logic host_chip_select_n;
    logic host_serial_clock;
    logic host_serial_in;
    logic host_serial_out;

    // ==========================================
    // Views of each end
    modport device (
        input  host_chip_select_n,
        input  host_serial_clock,
        input  host_serial_in,
        output host_serial_out
    );
    modport host (
        output host_chip_select_n,
        output host_serial_clock,
        output host_serial_in,
        input  host_serial_out
    );
endinterface
`default_nettype wire

// [rtl/host_spi_master.sv]
// Host end of the serial register port: sends one 40-bit frame per start pulse and
// returns the reply. Generates the link clock from clk by a divider.
// Assumes the device answers on the data-out pin after each falling clock edge.
`default_nettype none
module host_spi_master
    import spi_port_pkg::*;
#(
    parameter int HALF = spi_port_pkg::HALF_CYCLES,
    parameter int GAP  = spi_port_pkg::GAP_CYCLES
)
(
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    host_spi_if.host                             link,
    input  wire logic                            start,
    input  wire logic                            cmd_write,
    input  wire logic [spi_port_pkg::ADDR_BITS-1:0]   cmd_addr,
    input  wire logic [spi_port_pkg::DATA_BITS-1:0]   cmd_data,
    output logic                                 busy,
    output logic                                 done,
    output logic      [spi_port_pkg::STATUS_BITS-1:0] resp_status,
    output logic      [spi_port_pkg::DATA_BITS-1:0]   resp_data
);
    import spi_port_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_LEAD = 3'h1,
        ST_HIGH = 3'h2,
        ST_LOW  = 3'h3,
        ST_GAP  = 3'h4
    } state_e;

    // ==========================================
    // Registers
    state_e                state;
    state_e                next_state;
    logic [7:0]            phase;
    logic [7:0]            next_phase;
    logic [CNT_W-1:0]      bits;
    logic [CNT_W-1:0]      next_bits;
    logic [FRAME_BITS-1:0] tx;
    logic [FRAME_BITS-1:0] next_tx;
    logic [FRAME_BITS-1:0] rx;
    logic [FRAME_BITS-1:0] next_rx;
    logic                  cs_n;
    logic                  next_cs_n;
    logic                  sclk;
    logic                  next_sclk;
    logic                  next_done;
    logic [1:0]            sdo_sync;

    // Data-out is from another domain, so two flops before use.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sdo_sync <= '0;
        else
            sdo_sync <= {sdo_sync[0], link.host_serial_out};
    end

    // Mode with clock idle low: sample on the rise, shift on the fall.
    always_comb
    begin
        next_state = state;
        next_phase = (phase == 8'(HALF - 1)) ? 8'h00 : phase + 8'h01;
        next_bits  = bits;
        next_tx    = tx;
        next_rx    = rx;
        next_cs_n  = cs_n;
        next_sclk  = sclk;
        next_done  = 1'b0;
        case (state)
            ST_IDLE:
            begin
                next_phase = 8'h00;
                if (start)
                begin
                    next_tx    = {(cmd_write ? WRITE_FLAG[7] : 1'b0), cmd_addr, cmd_data};
                    next_cs_n  = 1'b0;
                    next_bits  = '0;
                    next_state = ST_LEAD;
                end
            end
            ST_LEAD, ST_LOW:
            begin
                if (phase == 8'(HALF - 1))
                begin
                    if (bits == FRAME_COUNT)
                    begin
                        next_cs_n  = 1'b1;
                        next_state = ST_GAP;
                    end
                    else
                    begin
                        next_sclk  = 1'b1;
                        next_rx    = {rx[FRAME_BITS-2:0], sdo_sync[1]};
                        next_bits  = bits + 6'h01;
                        next_state = ST_HIGH;
                    end
                end
            end
            ST_HIGH:
            begin
                if (phase == 8'(HALF - 1))
                begin
                    next_sclk  = 1'b0;
                    next_tx    = {tx[FRAME_BITS-2:0], 1'b0};
                    next_state = ST_LOW;
                end
            end
            ST_GAP:
            begin
                if (phase == 8'(HALF - 1) && bits == '0)
                begin
                    next_done  = 1'b1;
                    next_state = ST_IDLE;
                end
                else if (phase == 8'(HALF - 1))
                begin
                    next_bits = bits - 6'h01;
                end
                if (bits == FRAME_COUNT)
                    next_bits = 6'(GAP / HALF);
            end
            default:
            begin
                next_state = ST_IDLE;
                next_cs_n  = 1'b1;
                next_sclk  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            phase <= 8'h00;
            bits  <= '0;
            tx    <= '0;
            rx    <= '0;
            cs_n  <= 1'b1;
            sclk  <= 1'b0;
            done  <= 1'b0;
        end
        else
        begin
            state <= next_state;
            phase <= next_phase;
            bits  <= next_bits;
            tx    <= next_tx;
            rx    <= next_rx;
            cs_n  <= next_cs_n;
            sclk  <= next_sclk;
            done  <= next_done;
        end
    end

    assign link.host_chip_select_n = cs_n;
    assign link.host_serial_clock  = sclk;
    assign link.host_serial_in     = tx[FRAME_BITS-1];
    assign busy                    = (state != ST_IDLE);
    assign resp_status             = rx[FRAME_BITS-1:DATA_BITS];
    assign resp_data               = rx[DATA_BITS-1:0];

    // Half period of at least three clocks keeps the link at most a quarter of clk.
    if (HALF < 3 || HALF > 255 || GAP < HALF * 2)
    begin : g_bad_timing
        $error("host_spi_master: HALF must be 3..255 and GAP at least two halves.");
    end
endmodule
`default_nettype wire

// [sim/host_spi_port_assertions.sv]
// Checker for the serial lines shared by the host master and the device end.
// Assumes it sits beside the interface that joins both ends.
`default_nettype none
module host_spi_port_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic host_chip_select_n,
    input wire logic host_serial_clock,
    input wire logic host_serial_in,
    input wire logic host_serial_out
);
    logic       sclk_q;
    logic [6:0] rises;
    logic [6:0] next_rises;

    // ==========
    // Frame clock count
    // Counts serial clock rises per frame; cleared while deselected.
    always_comb
    begin
        next_rises = rises;
        if (host_chip_select_n)
            next_rises = 7'h00;
        else if (host_serial_clock && !sclk_q)
            next_rises = rises + 7'h01;
    end

    // Sampled on the system clock, which runs well above the serial rate.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q <= 1'b0;
            rises  <= 7'h00;
        end
        else
        begin
            sclk_q <= host_serial_clock;
            rises  <= next_rises;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ==========
    // Properties
    property p_frame_bits;
        $rose(host_chip_select_n) |-> rises == 7'h28;
    endproperty
    a_frame_bits: assert property (p_frame_bits) else $error("frame clock count wrong");
    property p_frame_len;
        $fell(host_chip_select_n) |-> ##[300:400] $rose(host_chip_select_n);
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame did not end in time");
    property p_cs_gap;
        $rose(host_chip_select_n) |-> host_chip_select_n [*5];
    endproperty
    a_cs_gap: assert property (p_cs_gap) else $error("select high too short");
    property p_sclk_high;
        $rose(host_serial_clock) |-> host_serial_clock [*4];
    endproperty
    a_sclk_high: assert property (p_sclk_high) else $error("clock high too short");
    property p_sclk_low;
        $fell(host_serial_clock) && !host_chip_select_n |-> !host_serial_clock [*4];
    endproperty
    a_sclk_low: assert property (p_sclk_low) else $error("clock low too short");
    property p_idle_clock;
        host_chip_select_n |-> !host_serial_clock;
    endproperty
    a_idle_clock: assert property (p_idle_clock) else $error("clock moved while deselected");
    property p_first_bit;
        $fell(host_chip_select_n) |-> !host_serial_clock [*4];
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("clock rose too soon after select");
    property p_sdi_hold;
        host_serial_clock |-> $stable(host_serial_in);
    endproperty
    a_sdi_hold: assert property (p_sdi_hold) else $error("data in moved while clock high");
    // Checked from the first high sample on, so a change at the rising edge itself is caught.
    property p_sdo_hold;
        host_serial_clock |-> $stable(host_serial_out);
    endproperty
    a_sdo_hold: assert property (p_sdo_hold) else $error("data out moved while clock high");
    property p_out_idle;
        host_chip_select_n && $past(host_chip_select_n) |-> !host_serial_out;
    endproperty
    a_out_idle: assert property (p_out_idle) else $error("data out not idle");

    c_frame: cover property ($fell(host_chip_select_n));
    c_full: cover property ($rose(host_chip_select_n) && rises == 7'h28);
    c_out_high: cover property (!host_chip_select_n && host_serial_out);
endmodule
`default_nettype wire

// [sim/host_spi_register_port_bench.sv]
// Bench: master and device back to back, plus a second device whose
// link the bench drives itself to send short and long frames on purpose.
// Assumes the package, interface and both ends are compiled first.
`default_nettype none
module host_spi_register_port_bench
    import spi_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        start = 1'b0;
    logic        cmd_write = 1'b0;
    logic [6:0]  cmd_addr = 7'h00;
    logic [31:0] cmd_data = 32'h0;
    logic [7:0]  ev = 8'h00;
    logic        busy, done, wr1, rd1, disc1, wr2, rd2, disc2;
    logic [7:0]  resp_status;
    logic [31:0] resp_data, wdata1, wdata2;
    logic [6:0]  addr1, addr2;
    logic [31:0] mem [0:127];
    logic [38:0] last2 = 39'h0;
    logic [47:0] got;
    logic [7:0]  st1 = 8'h00;
    logic [7:0]  st2 = 8'h00;
    logic [7:0]  sp;
    int          errors = 0;
    int          n_compared = 0;
    int          nw1 = 0, nd1 = 0, nw2 = 0, nd2 = 0, nr2 = 0, cycles = 0;

    host_spi_if link();
    host_spi_if link2();

    host_spi_master host_spi_master_inst (.clk(clk), .rst_n(rst_n), .link(link.host), .start(start),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .busy(busy), .done(done),
        .resp_status(resp_status), .resp_data(resp_data));
    host_spi_device host_spi_device_inst (.clk(clk), .rst_n(rst_n), .link(link.device), .event_status(ev),
        .reg_rdata(mem[addr1]), .reg_write(wr1), .reg_read(rd1), .reg_addr(addr1), .reg_wdata(wdata1),
        .frame_discarded(disc1));
    host_spi_device second_host_spi_device_inst (.clk(clk), .rst_n(rst_n), .link(link2.device),
        .event_status(ev), .reg_rdata({addr2, 25'h0}), .reg_write(wr2), .reg_read(rd2), .reg_addr(addr2),
        .reg_wdata(wdata2), .frame_discarded(disc2));
    host_spi_port_assertions host_spi_port_assertions_inst (.clk(clk), .rst_n(rst_n),
        .host_chip_select_n(link.host_chip_select_n), .host_serial_clock(link.host_serial_clock),
        .host_serial_in(link.host_serial_in), .host_serial_out(link.host_serial_out));

    // ==========
    // Tasks
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] seen);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One frame through the master; the reply holds the previous frame's result.
    task automatic xfer(input logic w, input logic [6:0] a, input logic [31:0] d, input logic [31:0] exp);
        int k;
        @(posedge clk);
        #2;
        ev = ev + 8'h1d;
        start = 1'b1;
        cmd_write = w;
        cmd_addr = a;
        cmd_data = d;
        @(posedge clk);
        #2;
        start = 1'b0;
        chk("busy", 48'h1, {47'h0, busy});
        k = 0;
        do
        begin
            @(posedge clk);
            #2;
            k++;
        end
        while (done !== 1'b1 && k < 1000);
        chk("done", 48'h1, {47'h0, done});
        chk("reply status", {40'h0, st1}, {40'h0, resp_status});
        chk("reply data", {16'h0, exp}, {16'h0, resp_data});
        st1 = ev;
    endtask

    // Any number of bits on the second link at a 32 ns clock, which stands still between frames.
    task automatic bang(input int n, input logic [47:0] bits);
        sp = st2;
        ev = ev + 8'h3b;
        got = 48'h0;
        @(posedge clk);
        #2;
        link2.host_chip_select_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            link2.host_serial_in = bits[i];
            #16;
            link2.host_serial_clock = 1'b1;
            got[i] = link2.host_serial_out;
            #16;
            link2.host_serial_clock = 1'b0;
        end
        // Select stays low across two clk edges, so even a frame without clocks is seen.
        #40;
        link2.host_chip_select_n = 1'b1;
        link2.host_serial_in = ~link2.host_serial_in;
        repeat (10) @(posedge clk);
        st2 = ev;
    endtask

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // System clock, 20 ns period.
    initial
    begin
        forever
            #10 clk = ~clk;
    end

    // Register file model and pulse tallies; a hung run is cut short here.
    always @(posedge clk)
    begin
        if (wr1)
            mem[addr1] <= wdata1;
        if (wr2)
            last2 <= {addr2, wdata2};
        nw1 <= nw1 + int'(wr1);
        nd1 <= nd1 + int'(disc1);
        nw2 <= nw2 + int'(wr2);
        nd2 <= nd2 + int'(disc2);
        nr2 <= nr2 + int'(rd2);
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            test_done();
        end
    end

    // ==========
    // Tests
    initial
    begin
        link2.host_chip_select_n = 1'b1;
        link2.host_serial_clock = 1'b0;
        link2.host_serial_in = 1'b0;
        foreach (mem[i])
            mem[i] = 32'h0;
        mem[5] = 32'h80000001;
        mem[127] = 32'h7fffffff;
        repeat (4) @(posedge clk);
        #2;
        rst_n = 1'b1;
        xfer(1'b1, 7'h22, 32'h00abcdef, 32'h0);
        xfer(1'b1, 7'h22, 32'h00123456, 32'h00abcdef);
        xfer(1'b0, 7'h05, 32'hffffffff, 32'h00123456);
        mem[5] = 32'h0;
        xfer(1'b0, 7'h7f, 32'h0, 32'h80000001);
        xfer(1'b0, 7'h00, 32'h0, 32'h7fffffff);
        xfer(1'b1, 7'h00, 32'h5a5a5a5a, 32'h0);
        xfer(1'b0, 7'h22, 32'h0, 32'h5a5a5a5a);
        xfer(1'b0, 7'h00, 32'h0, 32'h00123456);
        xfer(1'b0, 7'h05, 32'h0, 32'h5a5a5a5a);
        chk("writes", 48'h3, 48'(nw1));
        chk("discards", 48'h0, 48'(nd1));
        $display("test pipelined access done");
        bang(40, {8'h0, 8'h91, 32'hcafe0123});
        chk("first reply", {8'h0, sp, 32'h0}, got);
        bang(0, 48'h0);
        chk("empty flagged", 48'h1, 48'(nd2));
        chk("empty not replayed", 48'h1, 48'(nw2));
        bang(8, 48'h92);
        chk("short reply", {40'h0, sp}, got);
        chk("short flagged", 48'h2, 48'(nd2));
        bang(48, {8'h3c, 8'h92, 32'h89abcdef});
        chk("long reply", {sp, 32'hcafe0123, 8'h3c}, got);
        bang(40, {8'h0, 8'h12, 32'hffffffff});
        chk("last forty", {8'h0, sp, 32'h89abcdef}, got);
        chk("long command", {9'h0, 7'h12, 32'h89abcdef}, {9'h0, last2});
        bang(40, {8'h0, 8'h40, 32'h0});
        chk("read back", {8'h0, sp, 7'h12, 25'h0}, got);
        chk("link writes", 48'h2, 48'(nw2));
        chk("link reads", 48'h2, 48'(nr2));
        chk("link discards", 48'h2, 48'(nd2));
        $display("test frame length done");
        test_done();
    end
endmodule
`default_nettype wire
